// ---- src/muldiv_logic_op_decode_cfg.svh ----
// Opcode patterns, field positions and cycle counts for the decoder
`ifndef MULDIV_LOGIC_OP_DECODE_CFG_SVH
`define MULDIV_LOGIC_OP_DECODE_CFG_SVH
// ==========================================
// Opcode patterns and masks
`define OPC_GRP3 8'hF6
`define OPC_SIGNED_MULTIPLY_IMM 8'h69
`define OPC_AAM 8'hD4
`define OPC_AAD 8'hD5
`define OPC_AA_TAIL 8'h0A
`define OPC_CBW 8'h98
`define OPC_CWD 8'h99
`define OPC_SH1 8'hD0
`define OPC_SHCL 8'hD2
`define OPC_SHIMM 8'hC0
`define OPC_AND 8'h20
`define OPC_OR 8'h08
`define OPC_TEST_RM 8'h84
`define OPC_TEST_ACC 8'hA8
`define MASK_W 8'hFE
`define MASK_DW 8'hFC
`define MASK_S 8'hFD
// ==========================================
// Field positions and group codes
`define BIT_W 0
`define BIT_D 1
`define BIT_S 1
`define MOD_REG 2'h3
`define MOD_DISP8 2'h1
`define MOD_DISP16 2'h2
`define RM_DIRECT 3'h6
`define G3_TEST 3'h0
`define G3_SIGNED_MULTIPLY 3'h5
`define G3_UDIV 3'h6
`define G3_SIGNED_QUOTIENT 3'h7
`define SH_RESERVED 3'h6
// ==========================================
// Clock cycle counts
`define CYC_SIGNED_MULTIPLY_RB_MIN 9'd25
`define CYC_SIGNED_MULTIPLY_RB_MAX 9'd28
`define CYC_SIGNED_MULTIPLY_RW_MIN 9'd34
`define CYC_SIGNED_MULTIPLY_RW_MAX 9'd37
`define CYC_SIGNED_MULTIPLY_MB_MIN 9'd31
`define CYC_SIGNED_MULTIPLY_MB_MAX 9'd34
`define CYC_SIGNED_MULTIPLY_MW_MIN 9'd40
`define CYC_SIGNED_MULTIPLY_MW_MAX 9'd43
`define CYC_IMULI_R_MIN 9'd22
`define CYC_IMULI_R_MAX 9'd25
`define CYC_IMULI_M_MIN 9'd29
`define CYC_IMULI_M_MAX 9'd32
`define CYC_UDIV_RB 9'd29
`define CYC_UDIV_RW 9'd38
`define CYC_UDIV_MB 9'd35
`define CYC_UDIV_MW 9'd44
`define CYC_SIGNED_QUOTIENT_RB_MIN 9'd44
`define CYC_SIGNED_QUOTIENT_RB_MAX 9'd52
`define CYC_SIGNED_QUOTIENT_RW_MIN 9'd53
`define CYC_SIGNED_QUOTIENT_RW_MAX 9'd61
`define CYC_SIGNED_QUOTIENT_MB_MIN 9'd50
`define CYC_SIGNED_QUOTIENT_MB_MAX 9'd58
`define CYC_SIGNED_QUOTIENT_MW_MIN 9'd59
`define CYC_SIGNED_QUOTIENT_MW_MAX 9'd67
`define CYC_AAM 9'd19
`define CYC_AAD 9'd15
`define CYC_CBW 9'd2
`define CYC_CWD 9'd4
`define CYC_SH1_R 9'd2
`define CYC_SH1_M 9'd15
`define CYC_SHN_R 9'd5
`define CYC_SHN_M 9'd17
`define CYC_LOGIC_R 9'd3
`define CYC_LOGIC_M 9'd10
`define CYC_TESTI_R 9'd4
`define CYC_ACC_B 9'd3
`define CYC_ACC_W 9'd4
`define CYC_NARROW_ADD 9'd4
`endif

// ---- src/muldiv_logic_op_decode_pkg.sv ----
// Types shared by the decoder and its bench
package muldiv_logic_op_decode_pkg;
  typedef enum logic [15:0] {
    OP_NONE = 16'h0001, OP_SIGNED_MULTIPLY = 16'h0002, OP_SIGNED_MULTIPLY_IMM = 16'h0004,
    OP_UDIV = 16'h0008, OP_SIGNED_QUOTIENT = 16'h0010, OP_AAM = 16'h0020,
    OP_AAD = 16'h0040, OP_CBW = 16'h0080, OP_CWD = 16'h0100,
    OP_SHIFT1 = 16'h0200, OP_SHIFTN = 16'h0400, OP_AND = 16'h0800,
    OP_OR = 16'h1000, OP_TEST_RM = 16'h2000, OP_TEST_IMM = 16'h4000,
    OP_TEST_ACC = 16'h8000
  } op_e;
  typedef enum logic [2:0] {
    SH_ROTATE_LEFT = 3'h0, SH_ROTATE_RIGHT = 3'h1, SH_ROTATE_CARRY_LEFT = 3'h2,
    SH_ROTATE_CARRY_RIGHT = 3'h3, SH_LEFT_SHIFT = 3'h4,
    SH_LOGICAL_RIGHT_SHIFT = 3'h5, SH_UNUSED = 3'h6, SH_ARITHMETIC_RIGHT_SHIFT = 3'h7
  } shift_e;
  typedef enum logic [3:0] {
    ST_OPCODE = 4'h1, ST_MODRM = 4'h2, ST_TAIL = 4'h4, ST_BYTES = 4'h8
  } state_e;
  typedef struct packed {
    op_e op;
    shift_e shift_op;
    logic word;
    logic reg_is_dest;
    logic mem;
    logic [7:0] n;
  } dec_s;
  typedef struct packed {
    logic [8:0] min;
    logic [8:0] max;
  } cyc_s;
endpackage

// ---- src/muldiv_logic_op_decode.sv ----
// Opcode decoder and cycle-count lookup for the multiply, divide, shift and logic group
`timescale 1ns/1ps
`include "muldiv_logic_op_decode_cfg.svh"

module muldiv_logic_op_decode (
  input wire logic i_ref_clk,
  input wire logic i_rst,
  input wire logic [7:0] i_byte,
  input wire logic i_byte_valid,
  input wire logic [7:0] i_shift_amount,
  input wire logic i_narrow_bus,
  output muldiv_logic_op_decode_pkg::dec_s o_dec,
  output muldiv_logic_op_decode_pkg::cyc_s o_cyc,
  output logic o_valid,
  output logic o_bad
);
  import muldiv_logic_op_decode_pkg::*;

  // ==========================================
  // Strap synchroniser
  logic narrow_meta_r;
  logic narrow_r;
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      narrow_meta_r <= 1'b0;
      narrow_r <= 1'b0;
    end else begin
      narrow_meta_r <= i_narrow_bus;
      narrow_r <= narrow_meta_r;
    end
  end

  // ==========================================
  // Cycle lookup
  function automatic cyc_s lookup(input dec_s d, input logic narrow);
    cyc_s c;
    logic starred;
    c = '{min: 9'd0, max: 9'd0};
    starred = 1'b0;
    case (d.op)
      OP_SIGNED_MULTIPLY: begin
        starred = 1'b1;
        case ({d.mem, d.word})
          2'b00: c = '{min: `CYC_SIGNED_MULTIPLY_RB_MIN, max: `CYC_SIGNED_MULTIPLY_RB_MAX};
          2'b01: c = '{min: `CYC_SIGNED_MULTIPLY_RW_MIN, max: `CYC_SIGNED_MULTIPLY_RW_MAX};
          2'b10: c = '{min: `CYC_SIGNED_MULTIPLY_MB_MIN, max: `CYC_SIGNED_MULTIPLY_MB_MAX};
          default: c = '{min: `CYC_SIGNED_MULTIPLY_MW_MIN, max: `CYC_SIGNED_MULTIPLY_MW_MAX};
        endcase
      end
      OP_SIGNED_MULTIPLY_IMM: c = d.mem ? cyc_s'{min: `CYC_IMULI_M_MIN, max: `CYC_IMULI_M_MAX}
                             : cyc_s'{min: `CYC_IMULI_R_MIN, max: `CYC_IMULI_R_MAX};
      OP_UDIV: begin
        starred = 1'b1;
        case ({d.mem, d.word})
          2'b00: c = '{min: `CYC_UDIV_RB, max: `CYC_UDIV_RB};
          2'b01: c = '{min: `CYC_UDIV_RW, max: `CYC_UDIV_RW};
          2'b10: c = '{min: `CYC_UDIV_MB, max: `CYC_UDIV_MB};
          default: c = '{min: `CYC_UDIV_MW, max: `CYC_UDIV_MW};
        endcase
      end
      OP_SIGNED_QUOTIENT: begin
        starred = 1'b1;
        case ({d.mem, d.word})
          2'b00: c = '{min: `CYC_SIGNED_QUOTIENT_RB_MIN, max: `CYC_SIGNED_QUOTIENT_RB_MAX};
          2'b01: c = '{min: `CYC_SIGNED_QUOTIENT_RW_MIN, max: `CYC_SIGNED_QUOTIENT_RW_MAX};
          2'b10: c = '{min: `CYC_SIGNED_QUOTIENT_MB_MIN, max: `CYC_SIGNED_QUOTIENT_MB_MAX};
          default: c = '{min: `CYC_SIGNED_QUOTIENT_MW_MIN, max: `CYC_SIGNED_QUOTIENT_MW_MAX};
        endcase
      end
      OP_AAM: c = '{min: `CYC_AAM, max: `CYC_AAM};
      OP_AAD: c = '{min: `CYC_AAD, max: `CYC_AAD};
      OP_CBW: c = '{min: `CYC_CBW, max: `CYC_CBW};
      OP_CWD: c = '{min: `CYC_CWD, max: `CYC_CWD};
      OP_SHIFT1: c = d.mem ? cyc_s'{min: `CYC_SH1_M, max: `CYC_SH1_M}
                           : cyc_s'{min: `CYC_SH1_R, max: `CYC_SH1_R};
      OP_SHIFTN: begin
        c.min = (d.mem ? `CYC_SHN_M : `CYC_SHN_R) + {1'b0, d.n};
        c.max = c.min;
      end
      OP_AND, OP_OR: begin
        starred = 1'b1;
        c.min = d.mem ? `CYC_LOGIC_M : `CYC_LOGIC_R;
        c.max = c.min;
      end
      OP_TEST_RM: begin
        c.min = d.mem ? `CYC_LOGIC_M : `CYC_LOGIC_R;
        c.max = c.min;
      end
      OP_TEST_IMM: begin
        starred = 1'b1;
        c.min = d.mem ? `CYC_LOGIC_M : `CYC_TESTI_R;
        c.max = c.min;
      end
      OP_TEST_ACC: begin
        c.min = d.word ? `CYC_ACC_W : `CYC_ACC_B;
        c.max = c.min;
      end
      default: c = '{min: 9'd0, max: 9'd0};
    endcase
    if (narrow && starred && d.word && d.mem) begin
      c.min = c.min + `CYC_NARROW_ADD;
      c.max = c.max + `CYC_NARROW_ADD;
    end
    return c;
  endfunction

  // ==========================================
  // Byte stream decoder
  state_e state_r, state_nxt;
  logic [7:0] opc_r, opc_nxt;
  logic [2:0] left_r, left_nxt;
  dec_s dec_r, dec_nxt;
  dec_s out_dec_r, out_dec_nxt;
  cyc_s cyc_r, cyc_nxt;
  logic valid_r, valid_nxt;
  logic bad_r, bad_nxt;
  logic fin;
  logic [2:0] disp;
  logic [2:0] data;

  always_comb begin
    state_nxt = state_r;
    opc_nxt = opc_r;
    left_nxt = left_r;
    dec_nxt = dec_r;
    fin = 1'b0;
    bad_nxt = 1'b0;
    disp = 3'd0;
    data = 3'd0;
    if (i_byte_valid) begin
      case (state_r)
        ST_OPCODE: begin
          opc_nxt = i_byte;
          dec_nxt = '{op: OP_NONE, shift_op: SH_ROTATE_LEFT, word: i_byte[`BIT_W],
                      reg_is_dest: i_byte[`BIT_D], mem: 1'b0, n: 8'h01};
          if ((i_byte & `MASK_W) == `OPC_GRP3 || (i_byte & `MASK_S) == `OPC_SIGNED_MULTIPLY_IMM ||
              (i_byte & `MASK_W) == `OPC_SH1 || (i_byte & `MASK_W) == `OPC_SHCL ||
              (i_byte & `MASK_W) == `OPC_SHIMM || (i_byte & `MASK_DW) == `OPC_AND ||
              (i_byte & `MASK_DW) == `OPC_OR || (i_byte & `MASK_W) == `OPC_TEST_RM) begin
            state_nxt = ST_MODRM;
          end else if (i_byte == `OPC_AAM || i_byte == `OPC_AAD) begin
            state_nxt = ST_TAIL;
          end else if (i_byte == `OPC_CBW) begin
            dec_nxt.op = OP_CBW;
            fin = 1'b1;
          end else if (i_byte == `OPC_CWD) begin
            dec_nxt.op = OP_CWD;
            fin = 1'b1;
          end else if ((i_byte & `MASK_W) == `OPC_TEST_ACC) begin
            dec_nxt.op = OP_TEST_ACC;
            left_nxt = i_byte[`BIT_W] ? 3'd2 : 3'd1;
            state_nxt = ST_BYTES;
          end else begin
            bad_nxt = 1'b1;
          end
        end
        ST_MODRM: begin
          dec_nxt.mem = (i_byte[7:6] != `MOD_REG);
          dec_nxt.shift_op = shift_e'(i_byte[5:3]);
          if (i_byte[7:6] == `MOD_DISP8) begin
            disp = 3'd1;
          end else if (i_byte[7:6] == `MOD_DISP16 ||
                       (i_byte[7:6] == 2'h0 && i_byte[2:0] == `RM_DIRECT)) begin
            disp = 3'd2;
          end
          if ((opc_r & `MASK_W) == `OPC_GRP3) begin
            case (i_byte[5:3])
              `G3_SIGNED_MULTIPLY: dec_nxt.op = OP_SIGNED_MULTIPLY;
              `G3_UDIV: dec_nxt.op = OP_UDIV;
              `G3_SIGNED_QUOTIENT: dec_nxt.op = OP_SIGNED_QUOTIENT;
              `G3_TEST: begin
                dec_nxt.op = OP_TEST_IMM;
                data = opc_r[`BIT_W] ? 3'd2 : 3'd1;
              end
              default: dec_nxt.op = OP_NONE;
            endcase
          end else if ((opc_r & `MASK_S) == `OPC_SIGNED_MULTIPLY_IMM) begin
            dec_nxt.op = OP_SIGNED_MULTIPLY_IMM;
            dec_nxt.word = 1'b1;
            data = opc_r[`BIT_S] ? 3'd1 : 3'd2;
          end else if ((opc_r & `MASK_W) == `OPC_SH1) begin
            dec_nxt.op = OP_SHIFT1;
          end else if ((opc_r & `MASK_W) == `OPC_SHCL) begin
            dec_nxt.op = OP_SHIFTN;
            dec_nxt.n = i_shift_amount;
          end else if ((opc_r & `MASK_W) == `OPC_SHIMM) begin
            dec_nxt.op = OP_SHIFTN;
            data = 3'd1;
          end else if ((opc_r & `MASK_DW) == `OPC_AND) begin
            dec_nxt.op = OP_AND;
          end else if ((opc_r & `MASK_DW) == `OPC_OR) begin
            dec_nxt.op = OP_OR;
          end else begin
            dec_nxt.op = OP_TEST_RM;
          end
          if (dec_nxt.op == OP_NONE || ((dec_nxt.op == OP_SHIFT1 || dec_nxt.op == OP_SHIFTN) &&
              i_byte[5:3] == `SH_RESERVED)) begin
            bad_nxt = 1'b1;
            state_nxt = ST_OPCODE;
          end else if (disp + data == 3'd0) begin
            fin = 1'b1;
            state_nxt = ST_OPCODE;
          end else begin
            left_nxt = disp + data;
            state_nxt = ST_BYTES;
          end
        end
        ST_TAIL: begin
          state_nxt = ST_OPCODE;
          if (i_byte == `OPC_AA_TAIL) begin
            dec_nxt.op = (opc_r == `OPC_AAM) ? OP_AAM : OP_AAD;
            fin = 1'b1;
          end else begin
            bad_nxt = 1'b1;
          end
        end
        ST_BYTES: begin
          left_nxt = left_r - 3'd1;
          if (left_r == 3'd1) begin
            if ((opc_r & `MASK_W) == `OPC_SHIMM) begin
              dec_nxt.n = i_byte;
            end
            fin = 1'b1;
            state_nxt = ST_OPCODE;
          end
        end
        default: state_nxt = ST_OPCODE;
      endcase
    end
    valid_nxt = fin;
    out_dec_nxt = fin ? dec_nxt : out_dec_r;
    cyc_nxt = fin ? lookup(dec_nxt, narrow_r) : cyc_r;
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      state_r <= ST_OPCODE;
      opc_r <= 8'h00;
      left_r <= 3'd0;
      dec_r <= '{op: OP_NONE, shift_op: SH_ROTATE_LEFT, word: 1'b0,
                 reg_is_dest: 1'b0, mem: 1'b0, n: 8'h00};
      out_dec_r <= '{op: OP_NONE, shift_op: SH_ROTATE_LEFT, word: 1'b0,
                     reg_is_dest: 1'b0, mem: 1'b0, n: 8'h00};
      cyc_r <= '{min: 9'd0, max: 9'd0};
      valid_r <= 1'b0;
      bad_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      opc_r <= opc_nxt;
      left_r <= left_nxt;
      dec_r <= dec_nxt;
      out_dec_r <= out_dec_nxt;
      cyc_r <= cyc_nxt;
      valid_r <= valid_nxt;
      bad_r <= bad_nxt;
    end
  end

  assign o_dec = out_dec_r;
  assign o_cyc = cyc_r;
  assign o_valid = valid_r;
  assign o_bad = bad_r;

  // ==========================================
  // Checks
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (i_rst);

  property p_signed_multiply_cyc;
    o_valid && o_dec.op == OP_SIGNED_MULTIPLY && !o_dec.mem && !o_dec.word |-> o_cyc.min == 9'd25 &&
      o_cyc.max == 9'd28;
  endproperty
  a_signed_multiply_cyc: assert property (p_signed_multiply_cyc) else $error("multiply byte count wrong");
  property p_imuli;
    i_byte_valid && state_r == ST_OPCODE && i_byte == 8'h6B ##1 i_byte_valid && i_byte == 8'hC0
      ##1 i_byte_valid |=> o_valid && o_dec.op == OP_SIGNED_MULTIPLY_IMM && o_cyc.max == 9'd25;
  endproperty
  a_imuli: assert property (p_imuli) else $error("immediate multiply not decoded");
  property p_udiv;
    o_valid && o_dec.op == OP_UDIV && o_dec.mem && !o_dec.word |-> o_cyc.min == 9'd35;
  endproperty
  a_udiv: assert property (p_udiv) else $error("unsigned divide count wrong");
  property p_signed_quotient;
    o_valid && o_dec.op == OP_SIGNED_QUOTIENT |-> o_cyc.max - o_cyc.min == 9'd8;
  endproperty
  a_signed_quotient: assert property (p_signed_quotient) else $error("signed divide spread wrong");
  property p_aam;
    i_byte_valid && state_r == ST_OPCODE && i_byte == 8'hD4 ##1 i_byte_valid && i_byte == 8'h0A
      |=> o_valid && o_dec.op == OP_AAM && o_cyc.min == 9'd19;
  endproperty
  a_aam: assert property (p_aam) else $error("adjust multiply not decoded");
  property p_cbw;
    i_byte_valid && state_r == ST_OPCODE && i_byte == 8'h98 |=> o_valid && o_cyc.max == 9'd2;
  endproperty
  a_cbw: assert property (p_cbw) else $error("byte to word not decoded");
  property p_shn;
    o_valid && o_dec.op == OP_SHIFTN && !o_dec.mem |-> o_cyc.min == 9'd5 + {1'b0, o_dec.n};
  endproperty
  a_shn: assert property (p_shn) else $error("counted shift cycles wrong");
  property p_acc;
    o_valid && o_dec.op == OP_TEST_ACC |-> o_cyc.min == (o_dec.word ? 9'd4 : 9'd3);
  endproperty
  a_acc: assert property (p_acc) else $error("accumulator test cycles wrong");
  property p_narrow;
    o_valid && o_dec.op == OP_UDIV && o_dec.mem && o_dec.word |->
      o_cyc.min == ($past(narrow_r) ? 9'd48 : 9'd44);
  endproperty
  a_narrow: assert property (p_narrow) else $error("narrow bus penalty wrong");
  property p_exclusive;
    !(o_valid && o_bad);
  endproperty
  a_exclusive: assert property (p_exclusive) else $error("valid and bad together");

  c_signed_multiply: cover property (o_valid && o_dec.op == OP_SIGNED_MULTIPLY && o_dec.mem);
  c_shift_imm: cover property (o_valid && o_dec.op == OP_SHIFTN && o_dec.n > 8'h01);
  c_narrow: cover property (o_valid && narrow_r && o_dec.word && o_dec.mem);
  c_bad: cover property (o_bad);
endmodule

// ---- verif/byte_stream_model.sv ----
// Instruction byte source standing in for the fetch path in front of the decoder
`timescale 1ns/1ps
module byte_stream_model (
  input wire logic i_ref_clk,
  input wire logic i_rst,
  input wire logic i_slow,
  output logic [7:0] o_byte,
  output logic [7:0] o_shift_amount,
  output logic o_byte_valid
);
  // ==========================================
  // Pending bytes, each paired with the shift amount shown beside it
  logic [15:0] pend[$];
  logic [15:0] v;

  task automatic push(input logic [15:0] x);
    pend.push_back(x);
  endtask

  function automatic logic idle();
    return pend.size() == 0 && o_byte_valid == 1'b0;
  endfunction

  // ==========================================
  // One byte per edge; random stalls when slow; lines scramble while idle
  initial begin
    o_byte = 8'h00;
    o_shift_amount = 8'h00;
    o_byte_valid = 1'b0;
  end

  always @(posedge i_ref_clk) begin
    if (!i_rst && pend.size() > 0 && !(i_slow && $urandom_range(1, 0) == 0)) begin
      v = pend.pop_front();
      o_shift_amount <= v[15:8];
      o_byte <= v[7:0];
      o_byte_valid <= 1'b1;
    end else begin
      o_shift_amount <= ~o_shift_amount;
      o_byte <= ~o_byte;
      o_byte_valid <= 1'b0;
    end
  end
endmodule

// ---- verif/test_muldiv_logic_op_decode.sv ----
// Self-checking bench for the opcode decoder and cycle-count lookup
`timescale 1ns/1ps
module test_muldiv_logic_op_decode;
  import muldiv_logic_op_decode_pkg::*;
  typedef struct packed {
    logic bad;
    op_e op;
    logic [2:0] sh;
    logic w;
    logic d;
    logic m;
    logic [7:0] n;
    logic [8:0] mn;
    logic [8:0] mx;
    logic [1:0] care;
  } exp_s;

  // ==========================================
  // Signals and instances
  logic ref_clk;
  logic rst = 1'b1;
  logic narrow = 1'b0;
  logic slow = 1'b0;
  logic [7:0] byte_in;
  logic [7:0] amt_in;
  logic byte_valid;
  dec_s dec;
  cyc_s cyc;
  logic valid;
  logic bad;
  int n_errors = 0;
  int total_checks = 0;
  exp_s expq[$];

  muldiv_logic_op_decode uut (
    .i_ref_clk(ref_clk),
    .i_rst(rst),
    .i_byte(byte_in),
    .i_byte_valid(byte_valid),
    .i_shift_amount(amt_in),
    .i_narrow_bus(narrow),
    .o_dec(dec),
    .o_cyc(cyc),
    .o_valid(valid),
    .o_bad(bad)
  );

  byte_stream_model mdl (
    .i_ref_clk(ref_clk),
    .i_rst(rst),
    .i_slow(slow),
    .o_byte(byte_in),
    .o_shift_amount(amt_in),
    .o_byte_valid(byte_valid)
  );

  initial begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end

  // ==========================================
  // Expectations
  function automatic exp_s ok(op_e op, logic [7:0] opc, logic m, logic [8:0] mn,
                              logic [8:0] mx, logic [1:0] care = 2'h1);
    exp_s e;
    logic [8:0] p;
    e = '0;
    e.op = op;
    e.w = (op == OP_SIGNED_MULTIPLY_IMM) ? 1'b1 : opc[0];
    e.d = opc[1];
    e.m = m;
    e.care = care;
    p = (narrow && e.w && m && op inside {OP_SIGNED_MULTIPLY, OP_UDIV, OP_SIGNED_QUOTIENT, OP_AND, OP_OR,
        OP_TEST_IMM}) ? 9'h004 : 9'h000;
    e.mn = mn + p;
    e.mx = mx + p;
    return e;
  endfunction

  function automatic exp_s sh(op_e op, logic [7:0] opc, logic m, logic [8:0] base,
                              logic [7:0] n, int t);
    exp_s e;
    e = ok(op, opc, m, base + {1'b0, n}, base + {1'b0, n}, 2'h3);
    e.sh = 3'(t);
    e.n = n;
    return e;
  endfunction

  function automatic exp_s bad_e();
    exp_s e;
    e = '0;
    e.bad = 1'b1;
    return e;
  endfunction

  function automatic logic [7:0] r8();
    return 8'($urandom);
  endfunction

  // ==========================================
  // Comparison and driving tasks
  task automatic chk(input logic [15:0] got, input logic [15:0] want);
    total_checks++;
    if (got !== want) begin
      n_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, want);
    end
  endtask

  task automatic cmp_dec(input exp_s e);
    chk({14'h0000, valid, bad}, 16'h0002);
    chk(dec.op, e.op);
    chk({7'h00, cyc.min}, {7'h00, e.mn});
    chk({7'h00, cyc.max}, {7'h00, e.mx});
    if (e.care[0]) chk({13'h0000, dec.word, dec.reg_is_dest, dec.mem}, {13'h0000, e.w, e.d, e.m});
    if (e.care[1]) chk({5'h00, dec.shift_op, dec.n}, {5'h00, e.sh, e.n});
  endtask

  task automatic cmp_bad();
    chk({14'h0000, valid, bad}, 16'h0001);
  endtask

  task automatic run(input logic [47:0] b, input int nb, input exp_s e,
                     input logic [7:0] a = 8'h00);
    expq.push_back(e);
    for (int i = nb - 1; i >= 0; i--) mdl.push({a, b[8*i +: 8]});
  endtask

  task automatic drain();
    int k;
    k = 0;
    while ((!mdl.idle() || expq.size() > 0) && k < 3000) begin
      @(posedge ref_clk);
      k++;
    end
    if (k >= 3000) begin
      n_errors++;
      print_verdict();
    end else begin
      repeat (2) @(posedge ref_clk);
    end
  endtask

  task automatic print_verdict();
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  // ==========================================
  // Result monitor: each pulse takes the oldest note
  always @(posedge ref_clk) begin
    if (!rst && (valid === 1'b1 || bad === 1'b1)) begin
      if (expq.size() == 0) chk({14'h0000, valid, bad}, 16'h0000);
      else if (expq[0].bad) cmp_bad();
      else cmp_dec(expq[0]);
      if (expq.size() > 0) void'(expq.pop_front());
    end
  end

  initial begin
    repeat (20000) @(posedge ref_clk);
    n_errors++;
    print_verdict();
  end

  // ==========================================
  // Main sequence
  initial begin
    logic [7:0] c;
    logic [7:0] a;
    void'($urandom(45));
    repeat (4) @(posedge ref_clk);
    rst <= 1'b0;
    @(posedge ref_clk);
    #1;
    chk(dec.op, OP_NONE);
    chk({7'h00, cyc.max}, 16'h0000);
    chk({14'h0000, valid, bad}, 16'h0000);
    for (int p = 0; p < 2; p++) begin
      @(posedge ref_clk);
      narrow <= p[0];
      slow <= p[0];
      repeat (4) @(posedge ref_clk);
      run({8'hF6, 8'hE8}, 2, ok(OP_SIGNED_MULTIPLY, 8'hF6, 1'b0, 9'h019, 9'h01C));
      run({8'hF7, 8'hE8}, 2, ok(OP_SIGNED_MULTIPLY, 8'hF7, 1'b0, 9'h022, 9'h025));
      run({8'hF7, 8'h2E, r8(), r8()}, 4, ok(OP_SIGNED_MULTIPLY, 8'hF7, 1'b1, 9'h028, 9'h02B));
      run({8'hF6, 8'h6F, r8()}, 3, ok(OP_SIGNED_MULTIPLY, 8'hF6, 1'b1, 9'h01F, 9'h022));
      run({8'h69, 8'hC3, r8(), r8()}, 4, ok(OP_SIGNED_MULTIPLY_IMM, 8'h69, 1'b0, 9'h016, 9'h019));
      run({8'h6B, 8'h87, r8(), r8(), r8()}, 5, ok(OP_SIGNED_MULTIPLY_IMM, 8'h6B, 1'b1, 9'h01D, 9'h020));
      run({8'h6B, 8'hC0, r8()}, 3, ok(OP_SIGNED_MULTIPLY_IMM, 8'h6B, 1'b0, 9'h016, 9'h019));
      run({8'hF6, 8'hF1}, 2, ok(OP_UDIV, 8'hF6, 1'b0, 9'h01D, 9'h01D));
      run({8'hF7, 8'hF1}, 2, ok(OP_UDIV, 8'hF7, 1'b0, 9'h026, 9'h026));
      run({8'hF6, 8'h37}, 2, ok(OP_UDIV, 8'hF6, 1'b1, 9'h023, 9'h023));
      run({8'hF7, 8'hB7, r8(), r8()}, 4, ok(OP_UDIV, 8'hF7, 1'b1, 9'h02C, 9'h02C));
      run({8'hF6, 8'hFA}, 2, ok(OP_SIGNED_QUOTIENT, 8'hF6, 1'b0, 9'h02C, 9'h034));
      run({8'hF7, 8'hFA}, 2, ok(OP_SIGNED_QUOTIENT, 8'hF7, 1'b0, 9'h035, 9'h03D));
      run({8'hF6, 8'h3C}, 2, ok(OP_SIGNED_QUOTIENT, 8'hF6, 1'b1, 9'h032, 9'h03A));
      run({8'hF7, 8'h7C, r8()}, 3, ok(OP_SIGNED_QUOTIENT, 8'hF7, 1'b1, 9'h03B, 9'h043));
      run({8'hD4, 8'h0A}, 2, ok(OP_AAM, 8'hD4, 1'b0, 9'h013, 9'h013, 2'h0));
      run({8'hD5, 8'h0A}, 2, ok(OP_AAD, 8'hD5, 1'b0, 9'h00F, 9'h00F, 2'h0));
      run({8'hD4, 8'h0B}, 2, bad_e());
      run({8'h98}, 1, ok(OP_CBW, 8'h98, 1'b0, 9'h002, 9'h002, 2'h0));
      run({8'h99}, 1, ok(OP_CWD, 8'h99, 1'b0, 9'h004, 9'h004, 2'h0));
      run({8'h20, 8'hC1}, 2, ok(OP_AND, 8'h20, 1'b0, 9'h003, 9'h003));
      run({8'h23, 8'h06, r8(), r8()}, 4, ok(OP_AND, 8'h23, 1'b1, 9'h00A, 9'h00A));
      run({8'h0A, 8'h45, r8()}, 3, ok(OP_OR, 8'h0A, 1'b1, 9'h00A, 9'h00A));
      run({8'h09, 8'hD8}, 2, ok(OP_OR, 8'h09, 1'b0, 9'h003, 9'h003));
      run({8'h84, 8'hC0}, 2, ok(OP_TEST_RM, 8'h84, 1'b0, 9'h003, 9'h003));
      run({8'h85, 8'h47, r8()}, 3, ok(OP_TEST_RM, 8'h85, 1'b1, 9'h00A, 9'h00A));
      run({8'hF6, 8'hC2, r8()}, 3, ok(OP_TEST_IMM, 8'hF6, 1'b0, 9'h004, 9'h004));
      run({8'hF7, 8'h06, r8(), r8(), r8(), r8()}, 6,
          ok(OP_TEST_IMM, 8'hF7, 1'b1, 9'h00A, 9'h00A));
      run({8'hA8, r8()}, 2, ok(OP_TEST_ACC, 8'hA8, 1'b0, 9'h003, 9'h003));
      run({8'hA9, r8(), r8()}, 3, ok(OP_TEST_ACC, 8'hA9, 1'b0, 9'h004, 9'h004));
      run({8'hF6, 8'hC8}, 2, bad_e());
      run({8'hF7, 8'hE0}, 2, bad_e());
      run({8'hF4}, 1, bad_e());
      drain();
    end
    for (int t = 0; t < 8; t++) begin
      c = r8();
      a = r8();
      if (t == 6) begin
        run({8'hD0, 2'h3, 3'(t), 3'h0}, 2, bad_e());
      end else begin
        run({8'hD0, 2'h3, 3'(t), 3'h0}, 2, sh(OP_SHIFT1, 8'hD0, 1'b0, 9'h001, 8'h01, t));
        run({8'hD1, 2'h2, 3'(t), 3'h6, r8(), r8()}, 4,
            sh(OP_SHIFT1, 8'hD1, 1'b1, 9'h00E, 8'h01, t));
        run({8'hD2, 2'h3, 3'(t), 3'h2}, 2, sh(OP_SHIFTN, 8'hD2, 1'b0, 9'h005, a, t), a);
        run({8'hD3, 2'h0, 3'(t), 3'h7}, 2, sh(OP_SHIFTN, 8'hD3, 1'b1, 9'h011, a, t), a);
        run({8'hC1, 2'h3, 3'(t), 3'h1, c}, 3, sh(OP_SHIFTN, 8'hC1, 1'b0, 9'h005, c, t));
        run({8'hC0, 2'h1, 3'(t), 3'h0, r8(), c}, 4,
            sh(OP_SHIFTN, 8'hC0, 1'b1, 9'h011, c, t));
      end
    end
    drain();
    mdl.push({8'h00, 8'hF7});
    drain();
    rst <= 1'b1;
    repeat (3) @(posedge ref_clk);
    rst <= 1'b0;
    repeat (3) @(posedge ref_clk);
    #1;
    chk(dec.op, OP_NONE);
    chk({7'h00, cyc.max}, 16'h0000);
    run({8'h98}, 1, ok(OP_CBW, 8'h98, 1'b0, 9'h002, 9'h002, 2'h0));
    drain();
    print_verdict();
  end
endmodule
